// ==== hw/adcss_defines.vh ====
// Constants shared by the scan sequencer design files.
`ifndef ADCSS_DEFINES_VH
`define ADCSS_DEFINES_VH
// APB register byte offsets.
`define ADCSS_REG_CTRL 12'h000
`define ADCSS_REG_CMD 12'h004
`define ADCSS_REG_STATUS 12'h008
`define ADCSS_REG_TBL_ADDR 12'h00C
`define ADCSS_REG_TBL_DATA 12'h010
`define ADCSS_REG_LATCH 12'h014
`define ADCSS_REG_PACER 12'h018
`define ADCSS_REG_SCOUNT 12'h01C
`define ADCSS_REG_SFIFO 12'h020
`define ADCSS_REG_HFIFO 12'h024
`define ADCSS_REG_HCOUNT 12'h028
`define ADCSS_REG_TBL_LEN 12'h02C
// Control register fields.
`define ADCSS_CTRL_TABLE 0
`define ADCSS_CTRL_DOUT 1
`define ADCSS_CTRL_MARKER 2
`define ADCSS_CTRL_EXTPACE 3
`define ADCSS_CTRL_SRC_LO 4
`define ADCSS_CTRL_SRC_HI 6
`define ADCSS_CTRL_HSSEL_LO 7
`define ADCSS_CTRL_HSSEL_HI 8
`define ADCSS_CTRL_HALFIRQ 9
`define ADCSS_CTRL_W 10
// Command register bits; writing a one issues a pulse.
`define ADCSS_CMD_SWSTART 0
`define ADCSS_CMD_TBLRESET 1
`define ADCSS_CMD_TBLCLEAR 2
`define ADCSS_CMD_FIFOCLR 3
`define ADCSS_CMD_HSSAMPLE 4
`define ADCSS_CMD_STOP 5
// Conversion start sources.
`define ADCSS_SRC_SW 3'h0
`define ADCSS_SRC_PACER 3'h1
`define ADCSS_SRC_TRIG 3'h2
`define ADCSS_SRC_COUNT 3'h3
// Table entry fields (24 bits).
`define ADCSS_ENT_CH_LO 0
`define ADCSS_ENT_CH_HI 3
`define ADCSS_ENT_GAIN_LO 4
`define ADCSS_ENT_GAIN_HI 6
`define ADCSS_ENT_RANGE_LO 7
`define ADCSS_ENT_RANGE_HI 8
`define ADCSS_ENT_TYPE_LO 9
`define ADCSS_ENT_TYPE_HI 10
`define ADCSS_ENT_SKIP 11
`define ADCSS_ENT_DA1 12
`define ADCSS_ENT_DA2 13
`define ADCSS_ENT_DOUT_LO 16
`define ADCSS_ENT_DOUT_HI 23
// Input types.
`define ADCSS_TYPE_GROUND_REFERENCED_INPUT 2'h0
`define ADCSS_TYPE_FLOATING_REFERENCE_INPUT 2'h1
`define ADCSS_TYPE_DIFFERENTIAL_PAIR_INPUT 2'h2
// Conversion time.
`define ADCSS_CONV_NS 800
`define ADCSS_CLK_NS 4
`endif

// ==== hw/adcss_mem.v ====
// Simple dual-port synchronous memory (one write port, one read port) with registered read data.
`timescale 1ns/10ps
module adcss_mem #(
  parameter AW = 10,
  parameter DW = 24
) (
  input wire clk,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // adcss_mem

// ==== hw/adcss_top.v ====
// Scan sequencer for a 12-bit converter front end with APB registers.
// Contract
// - Latch mode uses one loaded channel, type and gain for every conversion.
// - Software may switch from latch mode into table scanning at any time.
// - Scan table holds 1024 entries of 24 bits, any channel order.
// - With output control on, entry output bits drive the second digital port.
// - Skip bit converts but does not store the result.
// - After table enable, clear and fill, pointer sits on first entry.
// - Each end of conversion advances pointer in table mode and writes result to FIFO unless skipped.
// - In marker mode the sampled high-speed inputs are stored too.
// - After the last filled entry the pointer wraps to the first.
// - Reset-table command puts the pointer on the first entry anytime.
// - Entries pick input type, gain 1 to 32 and input range.
// - Entry bits request simultaneous update of both analog outputs.
// - Channel select covers 16 single-ended or 8 differential inputs.
// - A conversion takes 0.8 us, so starts up to 1.25 MHz.
// - Starts come from software, pacer, triggers or a sample counter.
// - Pacer is an on-board counter or an external clock input.
// - Sample FIFO holds 1k samples; conversions stop when it is full.
// - Sample FIFO is internally addressed and strictly in order.
// - Half-full flag can raise an interrupt for burst reads.
// - Host moves data by programmed reads or interrupts.
// - High-speed inputs are sampled on a selected signal into a 1K FIFO.
// - Entries written to the high-speed FIFO are counted for the user timer.
`timescale 1ns/10ps
`include "adcss_defines.vh"
module adcss_top #(
  parameter TAW = 10,
  parameter FAW = 10,
  parameter PACER_W = 24
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [11:0] adc_data,
  input wire adc_eoc,
  output reg adc_convert,
  output reg [3:0] mux_channel,
  output reg [2:0] amp_gain,
  output reg [1:0] amp_range,
  output reg [1:0] input_type,
  output reg da_update,
  input wire ext_pacer,
  input wire ext_trigger,
  input wire [7:0] bit_programmable_port,
  input wire hs_ext_sample,
  output reg [7:0] port1_out,
  output reg port1_oe,
  output reg hs_count_pulse,
  output reg fifo_half_irq
);
  localparam integer CONV_CYC = (`ADCSS_CONV_NS + `ADCSS_CLK_NS - 1) / `ADCSS_CLK_NS;
  localparam [7:0] CONV_CNT = CONV_CYC[7:0];
  localparam ST_IDLE = 2'd0;
  localparam ST_CONV = 2'd1;
  localparam ST_STORE = 2'd2;
  localparam [FAW:0] FDEPTH = {1'b1, {FAW{1'b0}}};
  localparam [15:0] FDEPTH16 = {{(15-FAW){1'b0}}, FDEPTH};

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  reg [11:0] sync1_r;
  reg [11:0] sync2_r;
  reg [11:0] sync3_r;
  reg [11:0] data1_r;
  reg [11:0] data2_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 12'h000;
      sync2_r <= 12'h000;
      sync3_r <= 12'h000;
      data1_r <= 12'h000;
      data2_r <= 12'h000;
    end else begin
      sync1_r <= {hs_ext_sample, ext_trigger, ext_pacer, adc_eoc, bit_programmable_port};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      // Converter data takes the same two stages as its strobe, so both arrive together.
      data1_r <= adc_data;
      data2_r <= data1_r;
    end
  end
  wire [7:0] hs_in = sync2_r[7:0];
  wire eoc_rise = sync2_r[8] & ~sync3_r[8];
  wire ext_pace_rise = sync2_r[9] & ~sync3_r[9];
  wire trig_level = sync2_r[10];
  wire hs_ext_rise = sync2_r[11] & ~sync3_r[11];

  // ****************************************************************
  // APB slave
  // ****************************************************************
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire [11:0] a = paddr;
  reg [`ADCSS_CTRL_W-1:0] ctrl_r;
  reg [TAW-1:0] tbl_addr_r;
  reg [TAW:0] tbl_len_r;
  reg [11:0] latch_r;
  reg [PACER_W-1:0] pacer_load_r;
  reg [15:0] scount_load_r;
  reg [15:0] scount_r;
  reg [15:0] hs_count_r;
  wire cmd = wr && (a == `ADCSS_REG_CMD);
  wire sw_start = cmd & pwdata[`ADCSS_CMD_SWSTART];
  wire tbl_reset = cmd & pwdata[`ADCSS_CMD_TBLRESET];
  wire tbl_clear = cmd & pwdata[`ADCSS_CMD_TBLCLEAR];
  wire fifo_clr = cmd & pwdata[`ADCSS_CMD_FIFOCLR];
  wire hs_sw = cmd & pwdata[`ADCSS_CMD_HSSAMPLE];
  wire stop_cmd = cmd & pwdata[`ADCSS_CMD_STOP];
  wire tbl_we = wr && (a == `ADCSS_REG_TBL_DATA);
  wire table_mode = ctrl_r[`ADCSS_CTRL_TABLE];
  wire [2:0] src = ctrl_r[`ADCSS_CTRL_SRC_HI:`ADCSS_CTRL_SRC_LO];
  wire [1:0] hs_sel = ctrl_r[`ADCSS_CTRL_HSSEL_HI:`ADCSS_CTRL_HSSEL_LO];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= {`ADCSS_CTRL_W{1'b0}};
      tbl_addr_r <= {TAW{1'b0}};
      tbl_len_r <= {(TAW+1){1'b0}};
      latch_r <= 12'h000;
      pacer_load_r <= {PACER_W{1'b0}};
      scount_load_r <= 16'h0000;
    end else begin
      if (wr && a == `ADCSS_REG_CTRL) begin
        ctrl_r <= pwdata[`ADCSS_CTRL_W-1:0];
      end
      if (wr && a == `ADCSS_REG_LATCH) begin
        latch_r <= pwdata[11:0];
      end
      if (wr && a == `ADCSS_REG_PACER) begin
        pacer_load_r <= pwdata[PACER_W-1:0];
      end
      if (wr && a == `ADCSS_REG_SCOUNT) begin
        scount_load_r <= pwdata[15:0];
      end
      if (wr && a == `ADCSS_REG_TBL_ADDR) begin
        tbl_addr_r <= pwdata[TAW-1:0];
      end
      if (tbl_clear) begin
        tbl_addr_r <= {TAW{1'b0}};
        tbl_len_r <= {(TAW+1){1'b0}};
      end else if (tbl_we) begin
        tbl_addr_r <= tbl_addr_r + 1'b1;
        if ({1'b0, tbl_addr_r} >= tbl_len_r) begin
          tbl_len_r <= {1'b0, tbl_addr_r} + 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Scan table and read pointer
  // ****************************************************************
  reg [TAW-1:0] rd_ptr_r;
  wire [23:0] tbl_q;
  reg [1:0] state_r;
  reg [7:0] conv_cnt_r;
  reg running_r;
  reg [15:0] fifo_cnt_r;
  wire eoc_done = (state_r == ST_CONV) && (eoc_rise || conv_cnt_r == 8'h00);

  adcss_mem #(.AW(TAW), .DW(24)) u_table (
    .clk(pclk),
    .we(tbl_we),
    .waddr(tbl_addr_r),
    .wdata(pwdata[23:0]),
    .raddr(rd_ptr_r),
    .rdata(tbl_q)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr_r <= {TAW{1'b0}};
    end else if (tbl_reset || tbl_clear || tbl_we) begin
      rd_ptr_r <= {TAW{1'b0}};
    end else if (eoc_done && table_mode) begin
      if ({1'b0, rd_ptr_r} + 1'b1 >= tbl_len_r) begin
        rd_ptr_r <= {TAW{1'b0}};
      end else begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
  wire [23:0] entry = table_mode ? tbl_q : {12'h000, latch_r};

  // ****************************************************************
  // Pacer and start sources
  // ****************************************************************
  reg [PACER_W-1:0] pacer_r;
  reg pace_tick_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pacer_r <= {PACER_W{1'b0}};
      pace_tick_r <= 1'b0;
    end else begin
      pace_tick_r <= 1'b0;
      if (ctrl_r[`ADCSS_CTRL_EXTPACE]) begin
        pace_tick_r <= ext_pace_rise;
      end else if (pacer_r == {PACER_W{1'b0}}) begin
        pacer_r <= pacer_load_r;
        pace_tick_r <= 1'b1;
      end else begin
        pacer_r <= pacer_r - 1'b1;
      end
    end
  end

  wire fifo_full = fifo_cnt_r == FDEPTH16;
  reg start_req;
  always @* begin
    start_req = 1'b0;
    case (src)
      `ADCSS_SRC_SW: start_req = sw_start;
      `ADCSS_SRC_PACER: start_req = pace_tick_r;
      `ADCSS_SRC_TRIG: start_req = pace_tick_r & trig_level;
      `ADCSS_SRC_COUNT: start_req = pace_tick_r & running_r;
      default: start_req = 1'b0;
    endcase
  end

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  reg [11:0] result_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      conv_cnt_r <= 8'h00;
      running_r <= 1'b0;
      scount_r <= 16'h0000;
      adc_convert <= 1'b0;
      mux_channel <= 4'h0;
      amp_gain <= 3'h0;
      amp_range <= 2'h0;
      input_type <= 2'h0;
      da_update <= 1'b0;
      port1_out <= 8'h00;
      port1_oe <= 1'b0;
      result_r <= 12'h000;
    end else begin
      da_update <= 1'b0;
      port1_oe <= ctrl_r[`ADCSS_CTRL_DOUT];
      case (state_r)
        ST_IDLE: begin
          if (start_req && !fifo_full) begin
            state_r <= ST_CONV;
            conv_cnt_r <= CONV_CNT;
            adc_convert <= 1'b1;
            mux_channel <= entry[`ADCSS_ENT_CH_HI:`ADCSS_ENT_CH_LO];
            amp_gain <= entry[`ADCSS_ENT_GAIN_HI:`ADCSS_ENT_GAIN_LO];
            amp_range <= entry[`ADCSS_ENT_RANGE_HI:`ADCSS_ENT_RANGE_LO];
            input_type <= entry[`ADCSS_ENT_TYPE_HI:`ADCSS_ENT_TYPE_LO];
            da_update <= entry[`ADCSS_ENT_DA1] & entry[`ADCSS_ENT_DA2];
            if (ctrl_r[`ADCSS_CTRL_DOUT]) begin
              port1_out <= entry[`ADCSS_ENT_DOUT_HI:`ADCSS_ENT_DOUT_LO];
            end
          end
        end
        ST_CONV: begin
          adc_convert <= 1'b0;
          conv_cnt_r <= conv_cnt_r - 1'b1;
          if (eoc_done) begin
            result_r <= data2_r;
            state_r <= ST_STORE;
          end
        end
        ST_STORE: begin
          state_r <= ST_IDLE;
          if (src == `ADCSS_SRC_COUNT && running_r) begin
            scount_r <= scount_r - 1'b1;
            if (scount_r == 16'h0001) begin
              running_r <= 1'b0;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      // A host load of the sample count wins over the count-down of a store in the same cycle.
      if (wr && a == `ADCSS_REG_SCOUNT) begin
        scount_r <= pwdata[15:0];
        running_r <= 1'b1;
      end else if (stop_cmd) begin
        running_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Sample FIFO and high-speed input FIFO
  // ****************************************************************
  reg skip_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_r <= 1'b0;
    end else if (state_r == ST_IDLE && start_req) begin
      skip_r <= table_mode & entry[`ADCSS_ENT_SKIP];
    end
  end
  wire s_push = (state_r == ST_STORE) && !skip_r && !fifo_full;
  wire s_pop = acc && !pwrite && (a == `ADCSS_REG_SFIFO) && fifo_cnt_r != 16'h0000;
  reg [FAW-1:0] s_wp_r;
  reg [FAW-1:0] s_rp_r;
  wire [19:0] s_q;
  adcss_mem #(.AW(FAW), .DW(20)) u_sfifo (
    .clk(pclk),
    .we(s_push),
    .waddr(s_wp_r),
    .wdata({ctrl_r[`ADCSS_CTRL_MARKER] ? hs_in : 8'h00, result_r}),
    .raddr(s_rp_r),
    .rdata(s_q)
  );

  wire hs_tick = (hs_sel == 2'd0) ? hs_sw : (hs_sel == 2'd1) ? hs_ext_rise :
                 (hs_sel == 2'd2) ? pace_tick_r : eoc_done;
  reg [FAW:0] h_cnt_r;
  reg [FAW-1:0] h_wp_r;
  reg [FAW-1:0] h_rp_r;
  wire h_push = hs_tick && h_cnt_r != FDEPTH;
  wire h_pop = acc && !pwrite && (a == `ADCSS_REG_HFIFO) && h_cnt_r != {(FAW+1){1'b0}};
  wire [7:0] h_q;
  adcss_mem #(.AW(FAW), .DW(8)) u_hfifo (
    .clk(pclk),
    .we(h_push),
    .waddr(h_wp_r),
    .wdata(hs_in),
    .raddr(h_rp_r),
    .rdata(h_q)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_wp_r <= {FAW{1'b0}};
      s_rp_r <= {FAW{1'b0}};
      fifo_cnt_r <= 16'h0000;
      h_wp_r <= {FAW{1'b0}};
      h_rp_r <= {FAW{1'b0}};
      h_cnt_r <= {(FAW+1){1'b0}};
      hs_count_r <= 16'h0000;
      hs_count_pulse <= 1'b0;
      fifo_half_irq <= 1'b0;
    end else begin
      hs_count_pulse <= h_push;
      if (h_push) begin
        hs_count_r <= hs_count_r + 1'b1;
      end
      fifo_half_irq <= ctrl_r[`ADCSS_CTRL_HALFIRQ] && fifo_cnt_r >= (FDEPTH16 >> 1);
      if (fifo_clr) begin
        s_wp_r <= {FAW{1'b0}};
        s_rp_r <= {FAW{1'b0}};
        fifo_cnt_r <= 16'h0000;
        h_wp_r <= {FAW{1'b0}};
        h_rp_r <= {FAW{1'b0}};
        h_cnt_r <= {(FAW+1){1'b0}};
      end else begin
        if (s_push) begin
          s_wp_r <= s_wp_r + 1'b1;
        end
        if (s_pop) begin
          s_rp_r <= s_rp_r + 1'b1;
        end
        fifo_cnt_r <= fifo_cnt_r + {15'h0000, s_push} - {15'h0000, s_pop};
        if (h_push) begin
          h_wp_r <= h_wp_r + 1'b1;
        end
        if (h_pop) begin
          h_rp_r <= h_rp_r + 1'b1;
        end
        h_cnt_r <= h_cnt_r + {{FAW{1'b0}}, h_push} - {{FAW{1'b0}}, h_pop};
      end
    end
  end

  // ****************************************************************
  // Read mux; one wait state lets the memories present data.
  // ****************************************************************
  wire f_empty = fifo_cnt_r == 16'h0000;
  wire f_half = fifo_cnt_r >= (FDEPTH16 >> 1);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && penable && !pready) begin
        case (a)
          `ADCSS_REG_CTRL: prdata <= {22'h00_0000, ctrl_r};
          `ADCSS_REG_CMD: prdata <= 32'h0000_0000;
          `ADCSS_REG_STATUS: prdata <= {12'h000, fifo_cnt_r[FAW:0] & 11'h7FF, 5'h00, running_r,
                                        fifo_full, f_half, f_empty};
          `ADCSS_REG_TBL_ADDR: prdata <= {22'h00_0000, tbl_addr_r};
          `ADCSS_REG_TBL_DATA: prdata <= {8'h00, tbl_q};
          `ADCSS_REG_LATCH: prdata <= {20'h0_0000, latch_r};
          `ADCSS_REG_PACER: prdata <= {8'h00, pacer_load_r};
          `ADCSS_REG_SCOUNT: prdata <= {16'h0000, scount_r};
          `ADCSS_REG_SFIFO: prdata <= {12'h000, s_q};
          `ADCSS_REG_HFIFO: prdata <= {24'h00_0000, h_q};
          `ADCSS_REG_HCOUNT: prdata <= {16'h0000, hs_count_r};
          `ADCSS_REG_TBL_LEN: prdata <= {21'h00_0000, tbl_len_r};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule // adcss_top

// ==== verification/adcss_checker.sv ====
// Port-level checks for the scan sequencer.
`timescale 1ns/10ps
module adcss_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire adc_convert,
  input wire [3:0] mux_channel,
  input wire [2:0] amp_gain,
  input wire da_update,
  input wire fifo_half_irq
);
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  chk_ready_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("ready not in second access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_da_with_start: assert property (da_update |-> adc_convert)
    else $error("output update not aligned with start");
  chk_start_gap: assert property (adc_convert |=> !adc_convert [*8])
    else $error("start before conversion ended");
  chk_fields_hold: assert property (adc_convert |=> ($stable(mux_channel) && $stable(amp_gain)) [*8])
    else $error("channel fields moved in conversion");
  chk_irq_fall_cause: assert property ($fell(fifo_half_irq) |-> $past(pready) || $past(pready, 2))
    else $error("half flag fell without host access");
  cov_da: cover property (da_update);
  cov_err: cover property (pslverr);
  cov_half: cover property ($rose(fifo_half_irq));
endmodule // adcss_checker
bind adcss_top adcss_checker u_adcss_checker (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .adc_convert(adc_convert), .mux_channel(mux_channel),
  .amp_gain(amp_gain), .da_update(da_update), .fifo_half_irq(fifo_half_irq));

// ==== verification/adcss_conv_model.sv ====
// Behavioural converter that answers each start with an end-of-conversion edge.
`timescale 1ns/10ps
module adcss_conv_model (
  input wire pclk,
  input wire presetn,
  input wire adc_convert,
  input wire [3:0] mux_channel,
  input wire [2:0] amp_gain,
  input wire [1:0] amp_range,
  input wire slow,
  output reg adc_eoc,
  output reg [11:0] adc_data
);
  reg [7:0] cnt_r;
  reg [11:0] res_r;
  // Data outside the valid window toggles, so a stale sample equals the last result only on alternate cycles.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
      res_r <= 12'h000;
      adc_eoc <= 1'b0;
      adc_data <= 12'h000;
    end
    else begin
      if (adc_convert) begin
        cnt_r <= slow ? 8'd156 : 8'd18;
        res_r <= {mux_channel, amp_gain, amp_range, 3'h5};
      end
      else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'd1;
      end
      adc_eoc <= (cnt_r <= 8'd7) && (cnt_r >= 8'd2);
      adc_data <= ((cnt_r <= 8'd7) && (cnt_r >= 8'd2)) ? res_r : ~adc_data;
    end
  end
endmodule // adcss_conv_model

// ==== verification/tb.sv ====
// Self-checking bench for the scan sequencer.
`timescale 1ns/10ps
`include "adcss_defines.vh"
module tb;
  typedef struct packed {logic [23:0] ent; logic keep;} adcss_row_t;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0000_0000;
  reg [7:0] hs_port = 8'hc3;
  reg slow = 1'b0;
  reg trig = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, adc_eoc, adc_convert, da_update, port1_oe, hs_count_pulse, fifo_half_irq;
  wire [11:0] adc_data;
  wire [3:0] mux_channel;
  wire [2:0] amp_gain;
  wire [1:0] amp_range, input_type;
  wire [7:0] port1_out;
  integer fails = 0;
  integer total_checks = 0;
  integer k, n;
  reg [31:0] rd;
  reg er;
  reg [23:0] e;
  logic [31:0] q[$];
  adcss_row_t rows [0:2];
  always #2 pclk = ~pclk;
  adcss_top u_adcss_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_data(adc_data),
    .adc_eoc(adc_eoc), .adc_convert(adc_convert), .mux_channel(mux_channel), .amp_gain(amp_gain),
    .amp_range(amp_range), .input_type(input_type), .da_update(da_update), .ext_pacer(1'b0),
    .ext_trigger(trig), .bit_programmable_port(hs_port), .hs_ext_sample(1'b0), .port1_out(port1_out),
    .port1_oe(port1_oe), .hs_count_pulse(hs_count_pulse), .fifo_half_irq(fifo_half_irq));
  adcss_conv_model u_adcss_conv_model (.pclk(pclk), .presetn(presetn), .adc_convert(adc_convert),
    .mux_channel(mux_channel), .amp_gain(amp_gain), .amp_range(amp_range), .slow(slow), .adc_eoc(adc_eoc),
    .adc_data(adc_data));
  // ****
  // Tasks
  // ****
  task check(input [31:0] seen, input [31:0] exp, input string what);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer t;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t = t + 1;
    end while (pready !== 1'b1 && t < 64);
    if (t >= 64) fails = fails + 1;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task conv_wait;
    n = 0;
    while (adc_convert !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n = n + 1;
    end
    if (n >= 400) fails = fails + 1;
  endtask
  task count_starts(input integer cyc);
    n = 0;
    repeat (cyc) begin
      @(posedge pclk);
      if (adc_convert === 1'b1) n = n + 1;
    end
  endtask
  task test_done;
    $display("Checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    #(4 * 90000);
    fails = fails + 1;
    test_done;
  end
  initial begin
    rows[0] = {24'h81_3023, 1'b1};
    rows[1] = {24'h3c_0adc, 1'b0};
    rows[2] = {24'he7_1577, 1'b1};
    repeat (8) @(posedge pclk);
    check({adc_convert, da_update, port1_oe, pready, fifo_half_irq}, 0, "reset outputs");
    presetn <= 1'b1;
    apb(0, `ADCSS_REG_STATUS, 0);
    check(rd, 32'h0000_0001, "status");
    apb(0, 12'h0fc, 0);
    check(rd | {er, 31'h0}, 32'h8000_0000, "unmapped");
    apb(1, `ADCSS_REG_CMD, 32'h0000_0010);
    @(posedge pclk);
    check(hs_count_pulse, 1, "count pulse");
    apb(0, `ADCSS_REG_HCOUNT, 0);
    check(rd, 32'h0000_0001, "hs count");
    apb(0, `ADCSS_REG_HFIFO, 0);
    check(rd, 32'h0000_00c3, "hs sample");
    apb(1, `ADCSS_REG_LATCH, 32'h0000_0119);
    apb(1, `ADCSS_REG_PACER, 32'h0000_0027);
    apb(1, `ADCSS_REG_CTRL, 32'h0000_0210);
    conv_wait;
    check({mux_channel, amp_gain, amp_range, input_type}, {4'h9, 3'h1, 2'h2, 2'h0}, "latch fields");
    k = 0;
    do begin
      apb(0, `ADCSS_REG_STATUS, 0);
      k = k + 1;
    end while (rd[2] !== 1'b1 && k < 12000);
    check(rd, 32'h0008_0006, "status full");
    check(fifo_half_irq, 1, "half flag");
    n = 0;
    repeat (300) begin
      @(posedge pclk);
      if (adc_convert === 1'b1) n = n + 1;
    end
    check(n, 0, "starts while full");
    apb(1, `ADCSS_REG_CTRL, 32'h0000_0200);
    repeat (2) begin
      apb(0, `ADCSS_REG_SFIFO, 0);
      check(rd, {20'h0, 4'h9, 3'h1, 2'h2, 3'h5}, "latch sample");
    end
    apb(1, `ADCSS_REG_CMD, 32'h0000_0008);
    repeat (3) @(posedge pclk);
    check(fifo_half_irq, 0, "half flag clear");
    apb(1, `ADCSS_REG_CTRL, 32'h0000_0007);
    apb(1, `ADCSS_REG_CMD, 32'h0000_0004);
    apb(1, `ADCSS_REG_TBL_ADDR, 0);
    for (k = 0; k < 3; k = k + 1) apb(1, `ADCSS_REG_TBL_DATA, {8'h0, rows[k].ent});
    apb(0, `ADCSS_REG_TBL_LEN, 0);
    check(rd, 32'h0000_0003, "table length");
    apb(0, `ADCSS_REG_TBL_DATA, 0);
    check(rd, {8'h0, rows[0].ent}, "first entry");
    for (k = 0; k < 6; k = k + 1) begin
      if (k == 5) apb(1, `ADCSS_REG_CMD, 32'h0000_0002);
      e = rows[(k == 5) ? 0 : k % 3].ent;
      slow <= (k == 2);
      apb(1, `ADCSS_REG_CMD, 32'h0000_0001);
      conv_wait;
      check({mux_channel, amp_gain, amp_range, input_type}, {e[3:0], e[6:4], e[8:7], e[10:9]}, "fields");
      check({da_update, port1_out, port1_oe}, {e[12] & e[13], e[23:16], 1'b1}, "entry outputs");
      if (rows[(k == 5) ? 0 : k % 3].keep) q.push_back({12'h0, 8'hc3, e[3:0], e[6:4], e[8:7], 3'h5});
      n = 0;
      while (adc_eoc !== 1'b1 && n < 400) begin
        @(posedge pclk);
        n = n + 1;
      end
      if (n >= 400) fails = fails + 1;
      repeat (10) @(posedge pclk);
    end
    while (q.size() > 0) begin
      apb(0, `ADCSS_REG_SFIFO, 0);
      check(rd, q.pop_front(), "table sample");
    end
    apb(0, `ADCSS_REG_STATUS, 0);
    check(rd, 32'h0000_0001, "skip not stored");
    // The sample counter lets exactly three paced conversions through.
    apb(1, `ADCSS_REG_CTRL, 32'h0000_0030);
    apb(1, `ADCSS_REG_SCOUNT, 32'h0000_0003);
    count_starts(400);
    check(n, 3, "counted starts");
    apb(0, `ADCSS_REG_STATUS, 0);
    check(rd, 32'h0000_0600, "count status");
    apb(1, `ADCSS_REG_CTRL, 32'h0000_0020);
    for (k = 0; k < 2; k = k + 1) begin
      trig <= k[0];
      count_starts(120);
      check(n != 0, k, "trigger gated starts");
    end
    test_done;
  end
endmodule // tb
